// ---- pgstk_bank.sv ----
`timescale 1ns/100ps
module pgstk_bank
  import pgstk_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_irq_entry,
  input wire logic i_irq_return,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_hit,
  output logic [7:0] o_active_page_select,
  output logic o_auto_paging_enable
);
  typedef struct packed {
    logic en;
    logic [7:0] rdata;
    logic hit;
    logic [7:0] page;
  } pgstk_bank_t;
  pgstk_bank_t q, d;
  pgstk_stack_if sif ();
  logic [2:0] wr_sel;
  function automatic logic [3:0] pgstk_dec(input logic [7:0] a);
    pgstk_dec = {a == PGSTK_ADDR_CTL, a == PGSTK_ADDR_BOT, a == PGSTK_ADDR_MID, a == PGSTK_ADDR_TOP};
  endfunction
  logic [3:0] sel;
  always_comb begin
    sel = pgstk_dec(i_reg_addr);
    wr_sel = i_reg_wr ? sel[2:0] : 3'h0;
  end
  assign sif.push = i_irq_entry && q.en;
  assign sif.pop = i_irq_return && q.en && !i_irq_entry;
  pgstk_stack u_stack (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .s(sif.stk),
    .i_wr_sel(wr_sel),
    .i_wr_data(i_reg_wdata)
  );
  always_comb begin
    d = q;
    d.hit = i_reg_rd && (sel != 4'h0);
    d.rdata = 8'h00;
    if (i_reg_wr && sel[3]) begin
      d.en = i_reg_wdata[PGSTK_CTL_EN_BIT];
    end
    if (i_reg_rd) begin
      unique case (1'b1)
        sel[0]: d.rdata = sif.top;
        sel[1]: d.rdata = sif.mid;
        sel[2]: d.rdata = sif.bot;
        sel[3]: d.rdata = {7'h00, q.en};
        default: d.rdata = 8'h00;
      endcase
    end
    d.page = sif.top;
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '{en: PGSTK_RST_EN, rdata: 8'h00, hit: 1'b0, page: PGSTK_RST_ENTRY};
    end else begin
      q <= d;
    end
  end
  assign o_reg_rdata = q.rdata;
  assign o_reg_hit = q.hit;
  assign o_active_page_select = q.page;
  assign o_auto_paging_enable = q.en;

  no_auto_push_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !q.en && !i_reg_wr |=> $stable(sif.bot))
    else $error("Stack moved while paging disabled");

  read_bot_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_reg_rd && i_reg_addr == PGSTK_ADDR_BOT |=> o_reg_rdata == $past(sif.bot))
    else $error("Bottom read wrong");

  write_bot_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_reg_wr && i_reg_addr == PGSTK_ADDR_BOT && !sif.push && !sif.pop |=> sif.bot == $past(i_reg_wdata))
    else $error("Bottom write lost");

  page_zero_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    sif.push |=> ##1 o_active_page_select == PGSTK_AUTO_PAGE)
    else $error("No page zero on entry");

  read_top_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_reg_rd && i_reg_addr == PGSTK_ADDR_TOP
    |=> o_reg_rdata == $past(sif.top))
    else $error("Top read wrong");

  read_mid_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_reg_rd && i_reg_addr == PGSTK_ADDR_MID
    |=> o_reg_rdata == $past(sif.mid))
    else $error("Middle read wrong");

  read_ctl_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_reg_rd && i_reg_addr == PGSTK_ADDR_CTL
    |=> o_reg_rdata == {7'h00, $past(o_auto_paging_enable)})
    else $error("Control read wrong");

  mapped_hit_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_reg_rd && (i_reg_addr == PGSTK_ADDR_TOP || i_reg_addr == PGSTK_ADDR_MID || i_reg_addr == PGSTK_ADDR_BOT
      || i_reg_addr == PGSTK_ADDR_CTL) |=> o_reg_hit)
    else $error("Mapped read not answered");

  miss_quiet_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_reg_rd && i_reg_addr != PGSTK_ADDR_TOP && i_reg_addr != PGSTK_ADDR_MID && i_reg_addr != PGSTK_ADDR_BOT
      && i_reg_addr != PGSTK_ADDR_CTL |=> !o_reg_hit && o_reg_rdata == 8'h00)
    else $error("Unmapped read answered");

  idle_read_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !i_reg_rd
    |=> !o_reg_hit && o_reg_rdata == 8'h00)
    else $error("Read answer without read");

  read_no_effect_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_reg_rd && !i_reg_wr && !i_irq_entry && !i_irq_return
    |=> $stable(sif.top) && $stable(sif.mid) && $stable(sif.bot))
    else $error("Read changed the stack");

  write_top_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_reg_wr && i_reg_addr == PGSTK_ADDR_TOP && !sif.push && !sif.pop
    |=> sif.top == $past(i_reg_wdata) && $stable(sif.mid) && $stable(sif.bot))
    else $error("Top write touched other bytes");

  write_mid_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_reg_wr && i_reg_addr == PGSTK_ADDR_MID && !sif.push && !sif.pop
    |=> sif.mid == $past(i_reg_wdata) && $stable(sif.top) && $stable(sif.bot))
    else $error("Middle write touched other bytes");

  write_bot_only_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_reg_wr && i_reg_addr == PGSTK_ADDR_BOT && !sif.push && !sif.pop
    |=> $stable(sif.top) && $stable(sif.mid))
    else $error("Bottom write touched other bytes");

  quiet_stack_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !i_irq_entry && !i_irq_return && !i_reg_wr
    |=> $stable(sif.top) && $stable(sif.mid) && $stable(sif.bot))
    else $error("Stack moved without cause");

  ctl_set_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_reg_wr && i_reg_addr == PGSTK_ADDR_CTL && i_reg_wdata[PGSTK_CTL_EN_BIT]
    |=> o_auto_paging_enable)
    else $error("Paging enable not set");

  ctl_clear_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_reg_wr && i_reg_addr == PGSTK_ADDR_CTL && !i_reg_wdata[PGSTK_CTL_EN_BIT]
    |=> !o_auto_paging_enable)
    else $error("Paging enable not cleared");

  ctl_hold_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !(i_reg_wr && i_reg_addr == PGSTK_ADDR_CTL)
    |=> $stable(o_auto_paging_enable))
    else $error("Paging enable changed alone");

  off_hold_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !o_auto_paging_enable && !i_reg_wr
    |=> $stable(sif.top) && $stable(sif.mid))
    else $error("Upper entries moved while disabled");

  page_follow_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    1'b1
    |=> o_active_page_select == $past(sif.top))
    else $error("Active page does not follow top");

  entry_shift_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_irq_entry && o_auto_paging_enable
    |=> sif.top == PGSTK_AUTO_PAGE && sif.mid == $past(sif.top))
    else $error("Entry did not shift top");

  entry_bot_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_irq_entry && o_auto_paging_enable
    |=> sif.bot == $past(sif.mid))
    else $error("Entry did not overwrite bottom");

  return_top_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_irq_return && !i_irq_entry && o_auto_paging_enable
    |=> sif.top == $past(sif.mid))
    else $error("Return did not restore top");

  return_mid_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_irq_return && !i_irq_entry && o_auto_paging_enable
    |=> sif.mid == $past(sif.bot))
    else $error("Return did not move bottom up");

  return_page_a: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_irq_return && !i_irq_entry && o_auto_paging_enable
    |=> ##1 o_active_page_select == $past(sif.mid, 2))
    else $error("Return did not restore page");
endmodule

// ---- pgstk_core_model.sv ----
`timescale 1ns/100ps
module pgstk_core_model (
  input wire logic i_clk,
  output logic o_entry,
  output logic o_ret,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  initial {o_entry, o_ret, o_wr, o_rd, o_addr, o_wdata} = '0;
  // One strobe for one cycle, then a scrambled bus
  task automatic op(input int k, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    {o_wr, o_rd, o_entry, o_ret} <= {k == 0, k == 1, k == 2, k == 3};
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    {o_wr, o_rd, o_entry, o_ret} <= '0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
endmodule

// ---- pgstk_pkg.sv ----
package pgstk_pkg;
  localparam int PGSTK_DW = 8;
  localparam int PGSTK_DEPTH = 3;
  localparam logic [7:0] PGSTK_ADDR_TOP = 8'ha7;
  localparam logic [7:0] PGSTK_ADDR_MID = 8'h85;
  localparam logic [7:0] PGSTK_ADDR_BOT = 8'h86;
  localparam logic [7:0] PGSTK_ADDR_CTL = 8'he5;
  localparam int PGSTK_CTL_EN_BIT = 0;
  localparam logic [7:0] PGSTK_RST_ENTRY = 8'h00;
  localparam logic PGSTK_RST_EN = 1'b1;
  localparam logic [7:0] PGSTK_AUTO_PAGE = 8'h00;
endpackage

// ---- pgstk_stack.sv ----
`timescale 1ns/100ps
module pgstk_stack
  import pgstk_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  pgstk_stack_if.stk s,
  input wire logic [2:0] i_wr_sel,
  input wire logic [7:0] i_wr_data
);
  typedef struct packed {
    logic [7:0] top;
    logic [7:0] mid;
    logic [7:0] bot;
  } pgstk_st_t;
  pgstk_st_t q, d;
  always_comb begin
    d = q;
    if (s.push) begin
      d.top = PGSTK_AUTO_PAGE;
      d.mid = q.top;
      d.bot = q.mid;
    end else if (s.pop) begin
      d.top = q.mid;
      d.mid = q.bot;
    end else begin
      if (i_wr_sel[0]) d.top = i_wr_data;
      if (i_wr_sel[1]) d.mid = i_wr_data;
      if (i_wr_sel[2]) d.bot = i_wr_data;
    end
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= {PGSTK_RST_ENTRY, PGSTK_RST_ENTRY, PGSTK_RST_ENTRY};
    end else begin
      q <= d;
    end
  end
  assign s.top = q.top;
  assign s.mid = q.mid;
  assign s.bot = q.bot;
  push_shift_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.push |=> (s.bot == $past(s.mid)) && (s.top == PGSTK_AUTO_PAGE))
    else $error("Push did not shift stack");
  pop_shift_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s.pop && !s.push |=> (s.mid == $past(s.bot)) && (s.top == $past(s.mid)))
    else $error("Pop did not shift stack");
endmodule

// ---- pgstk_stack_if.sv ----
`timescale 1ns/100ps
interface pgstk_stack_if;
  logic push;
  logic pop;
  logic [7:0] top;
  logic [7:0] mid;
  logic [7:0] bot;
  modport ctl (output push, output pop, input top, input mid, input bot);
  modport stk (input push, input pop, output top, output mid, output bot);
endinterface

// ---- tb_pgstk_bank.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, b); end end
module tb_pgstk_bank;
  import pgstk_pkg::*;
  logic i_clk = 0, i_sys_rst = 1, ent, ret, wr, rd, hit, en;
  logic [7:0] addr, wdata, rdata, page;
  int err_count = 0, comparisons = 0, seed = 41, m_en = 1, ev;
  int s[$] = {0, 0, 0};
  logic [7:0] tbl[4] = '{PGSTK_ADDR_TOP, PGSTK_ADDR_MID, PGSTK_ADDR_BOT, PGSTK_ADDR_CTL};
  always #5 i_clk = ~i_clk;
  pgstk_core_model u_core (.i_clk(i_clk), .o_entry(ent), .o_ret(ret), .o_wr(wr), .o_rd(rd),
    .o_addr(addr), .o_wdata(wdata));
  pgstk_bank u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_irq_entry(ent), .i_irq_return(ret),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_hit(hit), .o_active_page_select(page), .o_auto_paging_enable(en));
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Bottom entry keeps its old value after a pop but is not tracked here, so -1 marks it unknown
  task automatic step(input int k, input logic [7:0] a, input logic [7:0] d);
    int e;
    int i;
    u_core.op(k, a, d);
    i = (a == tbl[0]) ? 0 : (a == tbl[1]) ? 1 : (a == tbl[2]) ? 2 : (a == tbl[3]) ? 3 : 4;
    e = (i < 3) ? s[i] : (i == 3) ? m_en : 0;
    @(negedge i_clk);
    `CHK(hit, k == 1 && i < 4)
    if (k != 1 || e >= 0) `CHK(rdata, (k == 1) ? e[7:0] : 8'h00)
    if (k == 0 && i < 3) s[i] = d;
    if (k == 0 && i == 3) m_en = d[0];
    if (k == 2 && m_en == 1) begin s.push_front(0); void'(s.pop_back()); end
    if (k == 3 && m_en == 1) begin void'(s.pop_front()); s.push_back(-1); end
    @(negedge i_clk);
    if (s[0] >= 0) `CHK(page, s[0][7:0])
    `CHK(en, m_en[0])
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 0;
    for (int j = 0; j < 4; j++) step(1, tbl[j], 8'h00);
    $display("test done: reset values");
    repeat (400) begin
      ev = $random(seed);
      step(ev[5:4], ev[2] ? tbl[ev[1:0]] : ev[15:8], ev[23:16]);
    end
    $display("test done: random operations");
    @(posedge i_clk);
    i_sys_rst <= 1;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 0;
    s = {0, 0, 0};
    m_en = 1;
    for (int j = 0; j < 4; j++) step(1, tbl[j], 8'h00);
    step(0, tbl[2], 8'h0f);
    step(3, 8'h00, 8'h00);
    step(1, tbl[1], 8'h00);
    step(3, 8'h00, 8'h00);
    step(0, tbl[2], 8'h5a);
    step(0, tbl[1], 8'h33);
    step(2, 8'h00, 8'h00);
    step(1, tbl[2], 8'h00);
    $display("test done: reset and stack walk");
    report_and_stop();
  end
  initial begin
    #50000;
    err_count++;
    report_and_stop();
  end
endmodule
